/* File: shared/phy_irq_pkg.sv */
// Purpose: Shared constants and types for the management-interrupt block.
// Assumes: 100 MHz core clock; register indices as seen on the serial link.
// Notes:   Bit positions name the status bits that feed the interrupt sources, and the alternative-mode select.
`default_nettype none
package phy_irq_pkg;
  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [4:0] REG_BSTAT     = 5'h01;
  localparam logic [4:0] REG_LPABIL    = 5'h05;
  localparam logic [4:0] REG_ANEXP     = 5'h06;
  localparam logic [4:0] REG_STD_LAST  = 5'h06;
  localparam logic [4:0] REG_VND_FIRST = 5'h10;
  localparam logic [4:0] REG_MODECS    = 5'h11;
  localparam logic [4:0] REG_FLAGS     = 5'h1d;
  localparam logic [4:0] REG_MASK      = 5'h1e;
  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int BIT_LINK     = 2;   // Basic status: link up.
  localparam int BIT_RFAULT   = 4;   // Basic status: remote fault.
  localparam int BIT_ANDONE   = 5;   // Basic status: negotiation complete.
  localparam int BIT_LPACK    = 14;  // Partner ability: acknowledge.
  localparam int BIT_PAGE     = 1;   // Expansion: page received.
  localparam int BIT_PDFAULT  = 4;   // Expansion: parallel detection fault.
  localparam int BIT_ENERGY   = 1;   // Mode control/status: energy detect.
  localparam int BIT_ALTSEL   = 6;   // Mode control/status: alternative mode.
  localparam int FLAG_ENERGY  = 7;
  localparam int FLAG_LINKDN  = 4;
  localparam int FLAG_RFAULT  = 5;
  localparam int FLAG_PDFAULT = 2;
  localparam int FLAG_PAGE    = 1;
  localparam logic [15:0] FLAGS_RESET = 16'h0080;
  localparam logic [15:0] MASK_RESET  = 16'h0000;
  localparam logic [15:0] UNIMPL_DATA = 16'hffff;
  // ---------------------------------------------------------------------------
  // Frame layout and timing
  // ---------------------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HDR_LAST     = 4'hc;
  localparam logic [3:0] DATA_LAST    = 4'hf;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int REARM_DELAY_MS  = 1000;
  localparam int REARM_PULSE_MS  = 256;
  localparam int REARM_DELAY_CYC = REARM_DELAY_MS * (1000000 / CLK_PERIOD_NS);
  localparam int REARM_PULSE_CYC = REARM_PULSE_MS * (1000000 / CLK_PERIOD_NS);
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic energy;
    logic an_done;
    logic rem_fault;
    logic link_up;
    logic lp_ack;
    logic pd_fault;
    logic page_rx;
  } phy_stat_t;
  typedef enum logic [2:0] {
    S_PRE = 3'b000, S_HDR = 3'b001, S_TA1 = 3'b010, S_TA2 = 3'b011, S_DATA = 3'b100
  } smi_state_t;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_ARMED = 2'b01, R_WAIT = 2'b10, R_PULSE = 2'b11
  } rearm_state_t;
endpackage
`default_nettype wire

/* File: rtl/phy_mgmt_interrupt_logic.sv */
// Purpose: Interrupt sources, mask and flags, reached over the two-wire management link.
// Assumes: Status inputs are on the core clock; link clock and data pins are not.
// Notes:   Link pins are sampled twice before use, so frame bits lag by two cycles.
`default_nettype none
module phy_mgmt_interrupt_logic
  import phy_irq_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR  = 5'h00,
  parameter logic [31:0] DELAY_CYC = 32'(REARM_DELAY_CYC),
  parameter logic [31:0] PULSE_CYC = 32'(REARM_PULSE_CYC)
) (
  // Clock and reset
  input  wire logic      core_clk_in,
  input  wire logic      nrst_in,
  // Serial management link
  input  wire logic      mdc_in,
  input  wire logic      mdio_in,
  output logic           mdio_out,
  output logic           mdio_oe_n_out,
  // Status from the transceiver core
  input  wire phy_stat_t stat_in,
  input  wire logic      an_restart_in,
  // Interrupt
  output logic           irq_out_n
);
  // ---------------------------------------------------------------------------
  // Link synchronisers
  // ---------------------------------------------------------------------------
  logic mdc_s1_ff, mdc_s2_ff, mdc_d_ff, mdio_s1_ff, mdio_s2_ff;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {mdc_s1_ff, mdc_s2_ff, mdc_d_ff, mdio_s1_ff, mdio_s2_ff} <= 5'h00;
    end else begin
      {mdc_s1_ff, mdc_s2_ff, mdc_d_ff} <= {mdc_in, mdc_s1_ff, mdc_s2_ff};
      {mdio_s1_ff, mdio_s2_ff}         <= {mdio_in, mdio_s1_ff};
    end
  end
  // Edge found at the core rate; the slow link clock leaves many cycles per bit.
  wire mdc_rise = mdc_s2_ff & ~mdc_d_ff;

  // ---------------------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------------------
  smi_state_t  state_ff;
  logic [5:0]  ones_ff;
  logic [3:0]  cnt_ff;
  logic [11:0] hdr_ff;
  logic [15:0] sh_ff;
  logic [4:0]  reg_ff;
  logic        is_rd_ff, mdio_out_ff, oe_n_ff;
  logic [15:0] mask_ff;
  logic [7:1]  flag_ff;
  logic        alt_ff;
  // Flags live in bits 7..1; the unused positions always read as zero.
  wire [15:0] flag_word = {8'h00, flag_ff, 1'b0};

  wire [12:0] hdr_next = {hdr_ff, mdio_s2_ff};
  wire        hdr_ok   = hdr_next[12] & (hdr_next[9:5] == PHY_ADDR);
  wire        hdr_end  = mdc_rise & (state_ff == S_HDR) & (cnt_ff == HDR_LAST);
  wire        rd_go    = hdr_end & hdr_ok & (hdr_next[11:10] == OP_READ);
  wire        wr_start = hdr_end & hdr_ok & (hdr_next[11:10] == OP_WRITE);
  wire [4:0]  rd_idx   = hdr_next[4:0];
  wire        wr_go    = mdc_rise & (state_ff == S_DATA) & ~is_rd_ff & (cnt_ff == DATA_LAST);
  wire [15:0] wr_word  = {sh_ff[14:0], mdio_s2_ff};
  wire        rd_flags = rd_go & (rd_idx == REG_FLAGS);
  wire        rd_bstat = rd_go & (rd_idx == REG_BSTAT);
  wire        rd_anexp = rd_go & (rd_idx == REG_ANEXP);
  wire        wr_flags = wr_go & (reg_ff == REG_FLAGS);

  // Register indices 0..6 and 16..31 answer; the gap reads all ones.
  function automatic logic reg_impl(input logic [4:0] idx);
    reg_impl = (idx <= REG_STD_LAST) | (idx >= REG_VND_FIRST);
  endfunction

  // Read data; registers not modelled here read as zero.
  function automatic logic [15:0] reg_read(input logic [4:0] idx);
    reg_read = 16'h0000;
    if (!reg_impl(idx)) reg_read = UNIMPL_DATA;
    else if (idx == REG_BSTAT) begin
      reg_read[BIT_LINK]   = stat_in.link_up;
      reg_read[BIT_RFAULT] = stat_in.rem_fault;
      reg_read[BIT_ANDONE] = stat_in.an_done;
    end else if (idx == REG_LPABIL) reg_read[BIT_LPACK] = stat_in.lp_ack;
    else if (idx == REG_ANEXP) begin
      reg_read[BIT_PAGE]    = stat_in.page_rx;
      reg_read[BIT_PDFAULT] = stat_in.pd_fault;
    end else if (idx == REG_MODECS) begin
      reg_read[BIT_ENERGY] = stat_in.energy;
      reg_read[BIT_ALTSEL] = alt_ff;
    end else if (idx == REG_FLAGS) reg_read = flag_word;
    else if (idx == REG_MASK) reg_read = mask_ff;
  endfunction

  // Preamble of 32 ones, then start, opcode, addresses, turnaround and data.
  // The device changes its data bit just after a rising link edge, so the
  // controller samples it on the following rising edge.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= S_PRE;
      ones_ff <= 6'h00;
      cnt_ff <= 4'h0;
      hdr_ff <= 12'h000;
      sh_ff <= 16'h0000;
      reg_ff <= 5'h00;
      is_rd_ff <= 1'b0;
      mdio_out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (mdc_rise) begin
      cnt_ff <= cnt_ff + 4'h1;
      case (state_ff)
        S_PRE: begin
          ones_ff <= mdio_s2_ff ? ((ones_ff < PREAMBLE_LEN) ? ones_ff + 6'h01 : ones_ff) : 6'h00;
          cnt_ff <= 4'h0;
          if (!mdio_s2_ff && ones_ff >= PREAMBLE_LEN) state_ff <= S_HDR;
        end
        S_HDR: begin
          hdr_ff <= hdr_next[11:0];
          if (cnt_ff == HDR_LAST) begin
            reg_ff <= rd_idx;
            is_rd_ff <= rd_go;
            sh_ff <= reg_read(rd_idx);
            state_ff <= (rd_go | wr_start) ? S_TA1 : S_PRE;
          end
        end
        S_TA1: begin
          mdio_out_ff <= 1'b0;
          oe_n_ff <= ~is_rd_ff;
          state_ff <= S_TA2;
        end
        S_TA2: begin
          cnt_ff <= 4'h0;
          if (is_rd_ff) begin
            mdio_out_ff <= sh_ff[15];
            sh_ff <= {sh_ff[14:0], 1'b0};
          end
          state_ff <= S_DATA;
        end
        S_DATA: begin
          if (is_rd_ff) begin
            mdio_out_ff <= sh_ff[15];
            sh_ff <= {sh_ff[14:0], 1'b0};
          end else sh_ff <= wr_word;
          if (cnt_ff == DATA_LAST) begin
            oe_n_ff <= 1'b1;
            ones_ff <= 6'h00;
            state_ff <= S_PRE;
          end
        end
        default: state_ff <= S_PRE;
      endcase
    end
  end
  assign mdio_out      = mdio_out_ff;
  assign mdio_oe_n_out = oe_n_ff;

  // ---------------------------------------------------------------------------
  // Mask and mode registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_ff <= MASK_RESET;
      alt_ff  <= 1'b0;
    end else if (wr_go) begin
      if (reg_ff == REG_MASK) mask_ff <= wr_word;
      if (reg_ff == REG_MODECS) alt_ff <= wr_word[BIT_ALTSEL];
    end
  end

  // ---------------------------------------------------------------------------
  // Source flags
  // ---------------------------------------------------------------------------
  wire [7:1] src = stat_in;
  logic [7:1] prev_ff;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) prev_ff <= 7'h00;
    else prev_ff <= src;
  end
  wire link_fall = prev_ff[FLAG_LINKDN] & ~src[FLAG_LINKDN];
  wire [7:1] ev, clr;
  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_src
      localparam bit LD = (gi == FLAG_LINKDN);
      localparam bit ST = (gi == FLAG_RFAULT) || LD;
      localparam bit NG = (gi == FLAG_PDFAULT) || (gi == FLAG_PAGE);
      wire cond = LD ? src[gi] : ~src[gi];
      wire own  = ~LD & prev_ff[gi] & ~src[gi];
      // Link-down only answers reads; the others also drop on their own fall.
      wire c_pri = rd_flags | own | (ST & rd_bstat)
                 | (NG & (rd_anexp | an_restart_in | link_fall));
      wire c_alt = wr_flags & wr_word[gi] & cond;
      assign ev[gi]  = LD ? link_fall : (src[gi] & ~prev_ff[gi]);
      assign clr[gi] = alt_ff ? c_alt : c_pri;
    end
  endgenerate
  // A new event wins over a clear in the same cycle, so no edge is lost.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) flag_ff <= FLAGS_RESET[7:1];
    else flag_ff <= ev | (flag_ff & ~clr);
  end

  // ---------------------------------------------------------------------------
  // Energy re-assertion after a release while energy stayed high
  // ---------------------------------------------------------------------------
  // Clearing the energy enable cancels the pending pulse, which is why service
  // routines are expected to do so.
  rearm_state_t rs_ff;
  logic [31:0]  rc_ff;
  wire e_rel  = ~alt_ff & flag_ff[FLAG_ENERGY] & clr[FLAG_ENERGY] & src[FLAG_ENERGY];
  wire e_fall = prev_ff[FLAG_ENERGY] & ~src[FLAG_ENERGY];
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rs_ff <= R_IDLE;
      rc_ff <= 32'h0;
    end else if (!mask_ff[FLAG_ENERGY]) begin
      rs_ff <= R_IDLE;
    end else begin
      rc_ff <= rc_ff + 32'h1;
      case (rs_ff)
        R_IDLE:  if (e_rel) rs_ff <= R_ARMED;
        R_ARMED: if (e_fall) begin
          rs_ff <= R_WAIT;
          rc_ff <= 32'h0;
        end
        R_WAIT:  if (rc_ff == DELAY_CYC - 32'h1) begin
          rs_ff <= R_PULSE;
          rc_ff <= 32'h0;
        end
        R_PULSE: if (rc_ff == PULSE_CYC - 32'h1) rs_ff <= R_IDLE;
        default: rs_ff <= R_IDLE;
      endcase
    end
  end

  // Output is a plain gate of stored flags, mask and rearm pulse state, so it needs no clock edge to move.
  wire pend = |(flag_word & mask_ff) | ((rs_ff == R_PULSE) & mask_ff[FLAG_ENERGY]);
  assign irq_out_n = ~pend;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence ta_rd;
    mdc_rise && state_ff == S_TA1 && is_rd_ff;
  endsequence
  chk_irq_enabled_flag: assert property (|(flag_word & mask_ff) |-> !irq_out_n)
    else $error("enabled flag without interrupt");
  chk_irq_both_modes: assert property (ev[1] && mask_ff[1] |=> !irq_out_n)
    else $error("event did not assert interrupt");
  chk_alt_by_write: assert property ($rose(alt_ff) |-> $past(wr_go && reg_ff == REG_MODECS))
    else $error("alternative mode without write");
  chk_energy_flag_set: assert property (ev[FLAG_ENERGY] |=> flag_ff[FLAG_ENERGY])
    else $error("energy flag not set");
  chk_flags_read_clear: assert property (!alt_ff && rd_flags && ev == 7'h00 |=> flag_word == 16'h0)
    else $error("flag read did not release");
  chk_linkdn_hold: assert property (!alt_ff && flag_ff[4] && !rd_bstat && !rd_flags |=> flag_ff[4])
    else $error("link-down released early");
  chk_pd_restart: assert property (!alt_ff && an_restart_in && !ev[2] |=> !flag_ff[2])
    else $error("restart did not release fault");
  chk_own_fall: assert property (!alt_ff && $fell(src[FLAG_PAGE]) |=> !flag_ff[FLAG_PAGE])
    else $error("fall did not release source");
  chk_rearm_pulse: assert property (rs_ff == R_PULSE && mask_ff[7] |-> !irq_out_n)
    else $error("rearm pulse not on output");
  chk_ta_drive: assert property (ta_rd |=> !mdio_oe_n_out && !mdio_out)
    else $error("turnaround zero not driven");
  chk_unimpl_ones: assert property (rd_go && !reg_impl(rd_idx) |=> sh_ff == UNIMPL_DATA)
    else $error("gap register not all ones");
  chk_mask_read: assert property (rd_go && rd_idx == REG_MASK && !wr_go |=> sh_ff == $past(mask_ff))
    else $error("mask readback wrong");
  chk_alt_keep: assert property (alt_ff && wr_flags && src[FLAG_RFAULT] && flag_ff[FLAG_RFAULT] |=> flag_ff[FLAG_RFAULT])
    else $error("alt flag cleared while active");
  chk_alt_enter: assert property (wr_go && reg_ff == REG_MODECS && wr_word[BIT_ALTSEL] |=> alt_ff)
    else $error("alternative mode not entered");
endmodule
`default_nettype wire

/* File: test/mgmt_ctrl_model.sv */
// Purpose: Behavioural station management controller that runs frames on the two-wire link.
// Assumes: Device at link address 0; link line has a pull-up when nobody drives it.
// Notes:   Half periods of 200 ns low and 210 ns high keep both edge spacing and full period above the minimum.
`default_nettype none
module mgmt_ctrl_model
  import phy_irq_pkg::*;
(
  // Core clock used only as a time base
  input  wire logic core_clk_in,
  // Device side of the data line
  input  wire logic dev_mdio_in,
  input  wire logic dev_oe_n_in,
  // Link towards the device
  output logic      mdc_out,
  output logic      mdio_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_drv;
  logic ctl_en;
  // -------------------------------------------------------------------------
  // Line resolution
  // -------------------------------------------------------------------------
  // Released line floats up, so a device that fails to drive reads as ones.
  assign mdio_line_out = !dev_oe_n_in ? dev_mdio_in : (ctl_en ? ctl_drv : 1'b1);
  initial begin
    mdc_out = 1'b0;
    ctl_drv = 1'b1;
    ctl_en  = 1'b0;
  end
  // -------------------------------------------------------------------------
  // Frame task
  // -------------------------------------------------------------------------
  // One full frame; data is sampled just before each rising clock edge.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, 5'h00, ra, 2'b10, wd};
    rd   = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk_in);
      mdc_out = 1'b0;
      ctl_en  = (op == OP_WRITE) || (i < 46);
      ctl_drv = bits[63 - i];
      repeat (20) @(negedge core_clk_in); // Low phase of 200 ns.
      if (op == OP_READ && i >= 48) begin
        rd = {rd[14:0], mdio_line_out};
      end
      mdc_out = 1'b1;
      repeat (20) @(negedge core_clk_in); // High phase of 200 ns; the next bit's wait adds 10 ns.
    end
    // Clock stands still between frames and the line is released.
    mdc_out = 1'b0;
    ctl_en  = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the management-interrupt block.
// Assumes: Shortened rearm delay and pulse so the energy case runs in a few cycles.
// Notes:   All inputs but the data line while the device drives it change on the falling core clock edge.
`default_nettype none
module tb_top
  import phy_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  localparam int PLS = 10;
  logic        core_clk;
  logic        nrst;
  logic        mdc;
  logic        mdio_line;
  logic        mdio_dev;
  logic        oe_n;
  logic        irq_n;
  logic        an_restart;
  phy_stat_t   stat;
  logic [15:0] rd;
  int          mismatches;
  int          checks_done;
  int          lows;
  logic [4:0]  rd_list [2] = '{5'h07, 5'h0f};
  // -------------------------------------------------------------------------
  // Design and partner
  // -------------------------------------------------------------------------
  phy_mgmt_interrupt_logic #(.PHY_ADDR(5'h00), .DELAY_CYC(32'(DLY)), .PULSE_CYC(32'(PLS)))
    u_phy_mgmt_interrupt_logic (
    .core_clk_in(core_clk), .nrst_in(nrst), .mdc_in(mdc), .mdio_in(mdio_line),
    .mdio_out(mdio_dev), .mdio_oe_n_out(oe_n), .stat_in(stat),
    .an_restart_in(an_restart), .irq_out_n(irq_n));
  mgmt_ctrl_model u_mgmt_ctrl_model (
    .core_clk_in(core_clk), .dev_mdio_in(mdio_dev), .dev_oe_n_in(oe_n),
    .mdc_out(mdc), .mdio_line_out(mdio_line));
  // Clock of 10 ns period.
  always #5 core_clk = ~core_clk;
  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] val);
    u_mgmt_ctrl_model.frame(OP_READ, ra, 16'h0000, val);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] val);
    logic [15:0] dummy;
    u_mgmt_ctrl_model.frame(OP_WRITE, ra, val, dummy);
    repeat (8) @(negedge core_clk); // Let the commit land before the next step.
  endtask
  // Settle a status change, then compare the interrupt line.
  task automatic irq_is(input string what, input logic exp);
    repeat (4) @(negedge core_clk);
    check(what, {15'h0000, irq_n}, {15'h0000, exp});
  endtask
  task automatic pulse_restart();
    an_restart = 1'b1;
    @(negedge core_clk);
    an_restart = 1'b0;
  endtask
  task automatic conclude();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // -------------------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------------------
  // About 19 frames of 2624 cycles are expected; 90000 cycles leaves ample margin.
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    conclude();
  end
  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    core_clk    = 1'b0;
    nrst        = 1'b0;
    stat        = '0;
    an_restart  = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    irq_is("irq after reset", 1'b1);
    rd_reg(REG_FLAGS, rd);
    check("flags reset", rd, FLAGS_RESET);
    rd_reg(REG_MODECS, rd);
    check("alt select reset", rd, 16'h0000);
    rd_reg(REG_MASK, rd);
    check("mask reset", rd, MASK_RESET);
    foreach (rd_list[k]) begin
      rd_reg(rd_list[k], rd);
      check("unimplemented read", rd, UNIMPL_DATA);
    end
    // Enable all sources and read the mask back.
    wr_reg(REG_MASK, 16'h00fe);
    rd_reg(REG_MASK, rd);
    check("mask readback", rd, 16'h00fe);
    // Link-down fires on the fall and survives restart and an expansion read.
    stat.link_up = 1'b1;
    irq_is("link rise quiet", 1'b1);
    rd_reg(REG_BSTAT, rd);
    check("status live link", rd, 16'h0004);
    stat.link_up = 1'b0;
    irq_is("link fall", 1'b0);
    pulse_restart();
    rd_reg(REG_ANEXP, rd);
    irq_is("link down held", 1'b0);
    rd_reg(REG_BSTAT, rd);
    irq_is("status read release", 1'b1);
    // Negotiation-complete source drops on its own fall.
    stat.an_done = 1'b1;
    irq_is("done rise", 1'b0);
    stat.an_done = 1'b0;
    irq_is("done fall", 1'b1);
    // Remote fault in primary mode is released by a status read.
    stat.rem_fault = 1'b1;
    irq_is("remote fault rise", 1'b0);
    rd_reg(REG_BSTAT, rd);
    check("status with fault", rd, 16'h0010);
    irq_is("status read fault release", 1'b1);
    stat.rem_fault = 1'b0;
    // Page received: own fall releases, then restart; parallel detection fault: expansion read.
    stat.page_rx = 1'b1;
    irq_is("page rise", 1'b0);
    stat.page_rx = 1'b0;
    irq_is("page fall", 1'b1);
    stat.page_rx = 1'b1;
    irq_is("page rise again", 1'b0);
    pulse_restart();
    irq_is("restart release", 1'b1);
    stat.pd_fault = 1'b1;
    irq_is("fault rise", 1'b0);
    rd_reg(REG_ANEXP, rd);
    irq_is("expansion read release", 1'b1);
    // Acknowledge source released by a flag read.
    stat.lp_ack = 1'b1;
    irq_is("ack rise", 1'b0);
    rd_reg(REG_FLAGS, rd);
    check("flags with ack", rd, 16'h0008);
    irq_is("flag read release", 1'b1);
    // Energy released while high comes back as a shortened pulse after the fall.
    stat.energy = 1'b1;
    irq_is("energy rise", 1'b0);
    rd_reg(REG_FLAGS, rd);
    check("energy flag", rd, 16'h0080);
    irq_is("energy read release", 1'b1);
    stat.energy = 1'b0;
    lows = 0;
    repeat (DLY + PLS + 30) begin
      @(negedge core_clk);
      lows += (irq_n === 1'b0);
    end
    check("rearm pulse length", 16'(lows), 16'(PLS));
    // Service routine drops the energy enable.
    wr_reg(REG_MASK, 16'h007e);
    // Alternative mode: release only by writing one while the source is quiet.
    wr_reg(REG_MODECS, 16'h0040);
    rd_reg(REG_MODECS, rd);
    check("alt select set", rd, 16'h0040);
    stat.rem_fault = 1'b1;
    irq_is("alt fault rise", 1'b0);
    wr_reg(REG_FLAGS, 16'h0020);
    irq_is("alt write while high", 1'b0);
    stat.rem_fault = 1'b0;
    irq_is("alt fall holds", 1'b0);
    wr_reg(REG_FLAGS, 16'h0020);
    irq_is("alt write release", 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
